// ### hw/ibl_ctl.sv
// Purpose: Exception arbitration, break entry, break flag protection and wait/stop control.
// Assumes: One clock; the core signals instruction boundaries and low-power opcodes as same-clock pulses.
// Notes:   Request lines and the break request come from pins or other domains and are synchronised here.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`include "ibl_defs.svh"

module ibl_ctl #(
    parameter int NSRC = `IBL_NUM_SRC                           // Number of maskable sources
) (
    input  wire logic                       clk_sys_i,          // System clock, 100 MHz
    input  wire logic                       sys_rst_i,          // Asynchronous reset, active high
    input  wire logic [`IBL_ADDR_W-1:0]     reg_addr_i,         // Register address
    input  wire logic [7:0]                 reg_wdata_i,        // Register write data
    input  wire logic                       reg_wr_i,           // Register write strobe
    input  wire logic                       reg_rd_i,           // Register read strobe
    output logic      [7:0]                 reg_rdata_o,        // Read data, cycle after strobe
    input  wire logic [NSRC-1:0]            irq_req_i,          // Live request lines, bit 0 is flag one
    input  wire logic [NSRC-1:0]            irq_en_i,           // Per-source enable bits
    input  wire logic                       brk_req_i,          // Break request from break unit
    input  wire logic                       emul_mode_i,        // Emulation mode level
    input  wire logic                       cpu_mask_i,         // Global interrupt mask bit
    input  wire logic                       instr_done_i,       // Pulse: instruction completed
    input  wire logic                       swi_exec_i,         // Pulse: software trap executed
    input  wire logic                       wait_exec_i,        // Pulse: wait executed
    input  wire logic                       stop_exec_i,        // Pulse: stop executed
    input  wire logic                       svc_done_i,         // Pulse: vector fetched, entry done
    input  wire logic                       flag_clr_req_i,     // Peripheral asks to clear a flag
    output ibl_pkg::ibl_state_t             state_o,            // Current sequencing state
    output logic                            entry_o,            // Interrupt entry in progress
    output logic      [4:0]                 vector_o,           // Arbitration result, latched
    output ibl_pkg::ibl_stack_t             stack_sel_o,        // Which PC value to stack
    output logic                            stack_hi_idx_o,     // Stack upper index register
    output logic                            mask_clr_o,         // Pulse: clear global mask
    output logic                            cpu_clk_en_o,       // Core clock enable
    output logic                            bus_clk_en_o,       // Bus clock output enable
    output logic                            ref_clk_en_o,       // Reference clock output enable
    output logic                            wdog_run_o,         // Watchdog counting
    output logic                            flag_clr_ok_o,      // Peripheral flag clear permitted
    output logic                            in_break_o          // Break state active
);
    import ibl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for foreign inputs

    logic [NSRC-1:0] req_s1_r;                                  // First stage, read by second only
    logic [NSRC-1:0] req_s2_r;                                  // Synchronised requests
    logic [1:0]      brk_sync_r;                                // Break request synchroniser

    // Two flops before any logic reads a pin
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_s1_r   <= '0;
            req_s2_r   <= '0;
            brk_sync_r <= 2'h0;
        end else begin
            req_s1_r   <= irq_req_i;
            req_s2_r   <= req_s1_r;
            brk_sync_r <= {brk_sync_r[0], brk_req_i};
        end
    end

    wire logic brk_s = brk_sync_r[1];                           // Synchronised break request

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration helpers

    // Lowest set index wins: lower flag number is higher priority
    function automatic logic [4:0] pick_src(input logic [NSRC-1:0] pend);
        logic [4:0] v;
        v = `IBL_VEC_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = 5'(i + 1);
            end
        end
        return v;
    endfunction

    // Eligible hardware sources: live and enabled
    wire logic [NSRC-1:0] elig = req_s2_r & irq_en_i;
    wire logic             hw_go = (|elig) && !cpu_mask_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Software-visible control

    logic brk_clr_en_r;                                         // Break clear enable
    logic short_rec_r;                                          // Short recovery option
    logic wdog_dis_r;                                           // Watchdog disable option
    logic brk_wait_r;                                           // Break exited wait
    logic brk_r;                                                // Break state

    // Control and option writes; flag registers ignore writes
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            brk_clr_en_r <= 1'b0;
            short_rec_r  <= 1'b0;
            wdog_dis_r   <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `IBL_OFF_BRK_CTRL: begin
                    brk_clr_en_r <= reg_wdata_i[`IBL_BRK_CLR_EN_BIT];
                end
                `IBL_OFF_OPTIONS: begin
                    short_rec_r <= reg_wdata_i[`IBL_OPT_SHORT_BIT];
                    wdog_dis_r  <= reg_wdata_i[`IBL_OPT_WDOG_BIT];
                end
                default: begin
                    // Flag registers and unmapped: no effect
                end
            endcase
        end
    end

    // Read mux, registered; reading never disturbs requests
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `IBL_RESET_BYTE;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `IBL_OFF_FLAGS_FIRST:  reg_rdata_o <= {req_s2_r[5:0], 2'h0};
                `IBL_OFF_FLAGS_SECOND: reg_rdata_o <= req_s2_r[13:6];
                `IBL_OFF_FLAGS_THIRD:  reg_rdata_o <= {2'h0, req_s2_r[19:14]};
                `IBL_OFF_BRK_CTRL:     reg_rdata_o <= {7'h00, brk_clr_en_r};
                `IBL_OFF_BRK_STAT:     reg_rdata_o <= {6'h00, brk_wait_r, 1'b0};
                `IBL_OFF_OPTIONS:      reg_rdata_o <= {6'h00, wdog_dis_r, short_rec_r};
                default:               reg_rdata_o <= `IBL_RESET_BYTE;
            endcase
        end else begin
            reg_rdata_o <= `IBL_RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    ibl_state_t  state_r;                                       // Current state
    logic [12:0] rec_cnt_r;                                     // Recovery counter, 13 bits
    logic [4:0]  vec_r;                                         // Latched arbitration result
    ibl_stack_t  stk_r;                                         // Latched stack selection
    logic        mask_clr_r;                                    // Mask clear pulse

    wire logic [12:0] rec_len = short_rec_r ? `IBL_REC_SHORT : `IBL_REC_LONG;

    // Reset outranks everything by being the asynchronous clear
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r    <= IBL_RUN;
            vec_r      <= `IBL_VEC_NONE;
            stk_r      <= IBL_STK_NONE;
            mask_clr_r <= 1'b0;
            brk_wait_r <= 1'b0;
        end else begin
            mask_clr_r <= 1'b0;
            case (state_r)
                IBL_RUN: begin
                    if (brk_s && instr_done_i) begin
                        state_r <= IBL_ENTRY;
                        vec_r   <= `IBL_VEC_SWI;
                        stk_r   <= IBL_STK_PC;
                    end else if (swi_exec_i) begin
                        state_r <= IBL_ENTRY;
                        vec_r   <= `IBL_VEC_SWI;
                        stk_r   <= IBL_STK_PC;
                    end else if (wait_exec_i) begin
                        state_r    <= IBL_WAIT;
                        mask_clr_r <= 1'b1;
                    end else if (stop_exec_i) begin
                        state_r    <= IBL_STOP;
                        mask_clr_r <= 1'b1;
                    end else if (instr_done_i && hw_go) begin
                        // Boundary check also covers return from service
                        state_r <= IBL_ENTRY;
                        vec_r   <= pick_src(elig);
                        stk_r   <= IBL_STK_PCM1;
                    end
                end
                IBL_WAIT: begin
                    if (brk_s && emul_mode_i) begin
                        state_r    <= IBL_ENTRY;
                        vec_r      <= `IBL_VEC_SWI;
                        stk_r      <= IBL_STK_PC;
                        brk_wait_r <= 1'b1;
                    end else if (hw_go) begin
                        state_r <= IBL_ENTRY;
                        vec_r   <= pick_src(elig);
                        stk_r   <= IBL_STK_PCM1;
                    end
                end
                IBL_STOP: begin
                    // Any enabled module request or a break starts recovery
                    if ((|elig) || brk_s) begin
                        state_r <= IBL_RECOV;
                    end
                end
                IBL_RECOV: begin
                    if (rec_cnt_r == rec_len - 13'h0001) begin
                        if (brk_s) begin
                            state_r <= IBL_ENTRY;
                            vec_r   <= `IBL_VEC_SWI;
                            stk_r   <= IBL_STK_PC;
                        end else if (|elig) begin
                            state_r <= IBL_ENTRY;
                            vec_r   <= pick_src(elig);
                            stk_r   <= IBL_STK_PCM1;
                        end else begin
                            state_r <= IBL_RUN;
                        end
                    end
                end
                IBL_ENTRY: begin
                    // Latched vector holds until serviced, or for a hardware entry until no eligible request remains with the mask clear
                    if (svc_done_i || (stk_r == IBL_STK_PCM1 && cpu_mask_i == 1'b0 && !hw_go)) begin
                        state_r <= IBL_RUN;
                        stk_r   <= IBL_STK_NONE;
                    end
                end
                default: begin
                    state_r <= IBL_RUN;
                end
            endcase
            // Reading the status byte is not a clear; software sees it until reset
        end
    end

    // Recovery counter: clear through stop, counting in recovery
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rec_cnt_r <= 13'h0000;
        end else if (state_r == IBL_RECOV) begin
            rec_cnt_r <= rec_cnt_r + 13'h0001;
        end else begin
            rec_cnt_r <= 13'h0000;
        end
    end

    // Break state: entered on break vector, left when break request drops
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            brk_r <= 1'b0;
        end else if (brk_s && state_r == IBL_ENTRY && vec_r == `IBL_VEC_SWI) begin
            brk_r <= 1'b1;
        end else if (!brk_s) begin
            brk_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Clearing is a one-way act, so leaving break never restores a flag;
    // a peripheral holding step one of a two-step clear re-asks after break
    assign flag_clr_ok_o  = flag_clr_req_i && (!brk_r || brk_clr_en_r);
    assign state_o        = state_r;
    assign entry_o        = (state_r == IBL_ENTRY);
    assign vector_o       = vec_r;
    assign stack_sel_o    = stk_r;
    assign stack_hi_idx_o = 1'b0;
    assign mask_clr_o     = mask_clr_r;
    assign cpu_clk_en_o   = (state_r == IBL_RUN) || (state_r == IBL_ENTRY);
    assign bus_clk_en_o   = (state_r != IBL_STOP);
    assign ref_clk_en_o   = (state_r != IBL_STOP);
    assign wdog_run_o     = !wdog_dis_r && (state_r != IBL_STOP);
    assign in_break_o     = brk_r;

endmodule

// ### common/ibl_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the exception and low-power unit.
// Assumes: Included by its bare name; definitions only.
// Notes:   Offsets are byte addresses on the plain register port.
`ifndef IBL_DEFS_SVH
`define IBL_DEFS_SVH

`define IBL_ADDR_W          16
`define IBL_OFF_FLAGS_FIRST 16'hFE04
`define IBL_OFF_FLAGS_SECOND 16'hFE05
`define IBL_OFF_FLAGS_THIRD 16'hFE06
`define IBL_OFF_BRK_CTRL    16'hFE03
`define IBL_OFF_BRK_STAT    16'hFE00
`define IBL_OFF_OPTIONS     16'hFE07
`define IBL_BRK_CLR_EN_BIT  0
`define IBL_BRK_WAIT_BIT    1
`define IBL_OPT_SHORT_BIT   0
`define IBL_OPT_WDOG_BIT    1
`define IBL_RESET_BYTE      8'h00
`define IBL_REC_LONG        13'h1000
`define IBL_REC_SHORT       13'h0020
`define IBL_NUM_SRC         20
`define IBL_VEC_SWI         5'h1F
`define IBL_VEC_NONE        5'h00

`endif

// ### common/ibl_pkg.sv
// Purpose: Types shared by the exception and low-power unit.
// Assumes: Constants come from ibl_defs.svh.
// Notes:   States are one-hot.
package ibl_pkg;

    // Power and exception sequencing states
    typedef enum logic [4:0] {
        IBL_RUN   = 5'h01,
        IBL_WAIT  = 5'h02,
        IBL_STOP  = 5'h04,
        IBL_RECOV = 5'h08,
        IBL_ENTRY = 5'h10
    } ibl_state_t;

    // What the core is told to stack
    typedef enum logic [1:0] {
        IBL_STK_NONE = 2'h0,
        IBL_STK_PC   = 2'h1,
        IBL_STK_PCM1 = 2'h2
    } ibl_stack_t;

endpackage

// ### bench/ibl_ctl_checker.sv
// Purpose: Port-level checks of the exception and low-power unit.
// Assumes: One clock domain; bound from the bench top file.
// Notes:   Recovery length is measured by a small helper counter.
`timescale 1ns/10ps
module ibl_ctl_checker (
    input wire logic                clk_sys_i,      // Clock
    input wire logic                sys_rst_i,      // Reset
    input wire logic                reg_rd_i,       // Read strobe
    input wire logic [7:0]          reg_rdata_o,    // Read data
    input wire logic                swi_exec_i,     // Trap pulse
    input wire logic                wait_exec_i,    // Wait pulse
    input wire logic                svc_done_i,     // Entry done
    input wire logic                flag_clr_req_i, // Clear request
    input wire ibl_pkg::ibl_state_t state_o,        // State
    input wire logic                entry_o,        // Entry active
    input wire logic [4:0]          vector_o,       // Vector
    input wire ibl_pkg::ibl_stack_t stack_sel_o,    // Stack choice
    input wire logic                stack_hi_idx_o, // Upper index
    input wire logic                mask_clr_o,     // Mask clear
    input wire logic                cpu_clk_en_o,   // Core clock
    input wire logic                bus_clk_en_o,   // Bus clock
    input wire logic                ref_clk_en_o,   // Reference clock
    input wire logic                flag_clr_ok_o,  // Clear allowed
    input wire logic                in_break_o      // Break state
);
    import ibl_pkg::*;
    logic [12:0] rec_cnt_r; // Cycles in recovery; 13 bits hold 4097
    ////////////////////////////////////////////////////////////////
    // Count recovery cycles, cleared whenever recovery is left
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            rec_cnt_r <= 13'h0000;
        else if (state_o == IBL_RECOV)
            rec_cnt_r <= rec_cnt_r + 13'h0001;
        else
            rec_cnt_r <= 13'h0000;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // A trap taken from plain running, then its entry
    sequence s_trap;
        swi_exec_i && state_o == IBL_RUN && !in_break_o;
    endsequence
    sequence s_trap_entry;
        entry_o && vector_o == 5'h1F && stack_sel_o == IBL_STK_PC;
    endsequence
    a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not idle");
    a_hi_idx_zero: assert property (stack_hi_idx_o == 1'h0)
        else $error("upper index stacked");
    a_clr_gate: assert property (!in_break_o |-> flag_clr_ok_o == flag_clr_req_i)
        else $error("clear permission wrong outside break");
    a_swi_entry: assert property (s_trap |=> s_trap_entry)
        else $error("trap entry wrong");
    a_hw_stack: assert property ($rose(entry_o) && vector_o inside {[1:20]} |-> stack_sel_o == IBL_STK_PCM1)
        else $error("hardware entry stacks wrong value");
    a_entry_hold: assert property (entry_o && !svc_done_i |=> !entry_o || $stable(vector_o))
        else $error("latched vector changed");
    a_svc_exit: assert property (entry_o && svc_done_i |=> state_o == IBL_RUN)
        else $error("entry not left after fetch");
    a_wait_entry: assert property (wait_exec_i && state_o == IBL_RUN && !swi_exec_i && !in_break_o
        |=> state_o == IBL_WAIT && mask_clr_o && !cpu_clk_en_o && bus_clk_en_o)
        else $error("wait entry wrong");
    a_stop_clocks: assert property (state_o == IBL_STOP |-> !bus_clk_en_o && !ref_clk_en_o && !cpu_clk_en_o)
        else $error("clocks running in stop");
    a_rec_len: assert property (state_o != IBL_RECOV && rec_cnt_r != 13'h0000
        |-> rec_cnt_r inside {[32:33], [4096:4097]})
        else $error("recovery length wrong");
endmodule

// ### bench/ibl_core_model.sv
// Purpose: Behavioural core giving instruction boundaries and vector fetch.
// Assumes: Four-cycle instructions on the unit's clock.
// Notes:   Fetch ends at the next slot, one to four cycles; hold stalls it.
`timescale 1ns/10ps
module ibl_core_model (
    input  wire logic clk_sys_i,    // Clock
    input  wire logic sys_rst_i,    // Reset, active high
    input  wire logic run_i,        // Allow instructions
    input  wire logic hold_i,       // Stall vector fetch
    input  wire logic entry_i,      // Unit asks for entry
    input  wire logic cpu_clk_en_i, // Core is clocked
    output logic      instr_done_o, // Boundary pulse
    output logic      svc_done_o    // Fetch done pulse
);
    logic [1:0] cyc_r; // Slot within an instruction
    ////////////////////////////////////////////////////////////////
    // No boundary while unclocked or stacking, as a real core would
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_r        <= 2'h0;
            instr_done_o <= 1'h0;
            svc_done_o   <= 1'h0;
        end else begin
            cyc_r        <= cyc_r + 2'h1;
            instr_done_o <= run_i && cpu_clk_en_i && !entry_i && cyc_r == 2'h3;
            svc_done_o   <= entry_i && !hold_i && cyc_r == 2'h3;
        end
    end
endmodule

// ### bench/ibl_ctl_tb.sv
// Purpose: Self-checking bench for the exception and low-power unit.
// Assumes: Core model gives boundaries and fetch; bench drives the rest.
// Notes:   Both recovery lengths run, so the test spans some 4400 cycles.
`timescale 1ns/10ps
`include "ibl_defs.svh"
bind ibl_ctl ibl_ctl_checker chk_u (.clk_sys_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o, .swi_exec_i, .wait_exec_i,
    .svc_done_i, .flag_clr_req_i, .state_o, .entry_o, .vector_o, .stack_sel_o, .stack_hi_idx_o, .mask_clr_o,
    .cpu_clk_en_o, .bus_clk_en_o, .ref_clk_en_o, .flag_clr_ok_o, .in_break_o);
module ibl_ctl_tb;
    import ibl_pkg::*;
    logic        clk_sys_i = 1'h0, sys_rst_i = 1'h1;                         // Clock, reset
    logic [15:0] reg_addr_i = 16'h0000;                                      // Address
    logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;                           // Data
    logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0, run_i = 1'h0, hold_i = 1'h0; // Strobes, core
    logic [19:0] irq_req_i = 20'h00000, irq_en_i = 20'h00000;                // Requests
    logic        brk_req_i = 1'h0, emul_mode_i = 1'h0, cpu_mask_i = 1'h1;    // Break, mask
    logic        swi_exec_i = 1'h0, wait_exec_i = 1'h0, stop_exec_i = 1'h0;  // Opcodes
    logic        flag_clr_req_i = 1'h0, instr_done_i, svc_done_i, entry_o;   // Core link
    logic        stack_hi_idx_o, mask_clr_o, cpu_clk_en_o, bus_clk_en_o;     // Status
    logic        ref_clk_en_o, wdog_run_o, flag_clr_ok_o, in_break_o;        // Status
    logic [4:0]  vector_o;                                                   // Vector
    ibl_state_t  state_o;                                                    // State
    ibl_stack_t  stack_sel_o;                                                // Stack choice
    int          mismatches = 0, n_compared = 0, n;                          // Counters
    ////////////////////////////////////////////////////////////////
    ibl_ctl dut_u (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .irq_req_i, .irq_en_i, .brk_req_i, .emul_mode_i, .cpu_mask_i, .instr_done_i, .swi_exec_i,
        .wait_exec_i, .stop_exec_i, .svc_done_i, .flag_clr_req_i, .state_o, .entry_o, .vector_o,
        .stack_sel_o, .stack_hi_idx_o, .mask_clr_o, .cpu_clk_en_o, .bus_clk_en_o, .ref_clk_en_o,
        .wdog_run_o, .flag_clr_ok_o, .in_break_o);
    ibl_core_model core_u (.clk_sys_i, .sys_rst_i, .run_i, .hold_i, .entry_i(entry_o),
        .cpu_clk_en_i(cpu_clk_en_o), .instr_done_o(instr_done_i), .svc_done_o(svc_done_i));
    // Free-running 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    task automatic rst_unit;
        sys_rst_i <= 1'h1;
        cyc(20);
        sys_rst_i <= 1'h0;
        cyc(2);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'h0;
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    // One-cycle opcode pulse: trap, wait, stop
    task automatic op(input logic [2:0] k);
        @(posedge clk_sys_i);
        {swi_exec_i, wait_exec_i, stop_exec_i} <= k;
        @(posedge clk_sys_i);
        {swi_exec_i, wait_exec_i, stop_exec_i} <= 3'h0;
    endtask
    // Bounded wait for a state, sampled on falling edges where outputs are settled
    task automatic wait_st(input ibl_state_t s, input int lim);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (state_o !== s && n < lim);
        chk(state_o, s);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [19:0] pat [3] = '{20'h00000, 20'hFFFFF, 20'h5A3C6};
        logic [7:0]  d;
        foreach (pat[i]) begin
            irq_req_i <= pat[i];
            cyc(4);
            rd(`IBL_OFF_FLAGS_FIRST, d);
            chk(d, {pat[i][5:0], 2'h0});
            wr(`IBL_OFF_FLAGS_SECOND, 8'hFF);
            rd(`IBL_OFF_FLAGS_SECOND, d);
            chk(d, pat[i][13:6]);
            rd(`IBL_OFF_FLAGS_THIRD, d);
            chk(d, {2'h0, pat[i][19:14]});
        end
        rd(16'hFE0F, d);
        chk(d, 8'h00);
        irq_req_i <= 20'h00000;
    endtask
    task automatic t_prio;
        irq_req_i <= 20'h00408;
        irq_en_i  <= 20'hFFFFF;
        run_i     <= 1'h1;
        cyc(12);
        chk(entry_o, 1'h0);
        irq_en_i   <= 20'h00000;
        cpu_mask_i <= 1'h0;
        cyc(12);
        chk(entry_o, 1'h0);
        // Let the last boundary pulse drain before enabling, or it would start an entry
        run_i <= 1'h0;
        cyc(2);
        irq_en_i <= 20'hFFFFF;
        cyc(12);
        chk(entry_o, 1'h0);
        hold_i <= 1'h1;
        run_i  <= 1'h1;
        wait_st(IBL_ENTRY, 8);
        chk(vector_o, 5'h04);
        chk(stack_sel_o, IBL_STK_PCM1);
        irq_req_i <= 20'h00409;
        cyc(8);
        chk(vector_o, 5'h04);
        irq_req_i <= 20'h00401;
        cyc(4);
        hold_i <= 1'h0;
        wait_st(IBL_RUN, 8);
        wait_st(IBL_ENTRY, 8);
        chk(vector_o, 5'h01);
        run_i     <= 1'h0;
        irq_req_i <= 20'h00000;
        wait_st(IBL_RUN, 8);
    endtask
    task automatic t_swi_wait;
        cpu_mask_i <= 1'h1;
        op(3'h4);
        wait_st(IBL_ENTRY, 4);
        chk(vector_o, `IBL_VEC_SWI);
        chk(stack_sel_o, IBL_STK_PC);
        chk(stack_hi_idx_o, 1'h0);
        wait_st(IBL_RUN, 8);
        op(3'h2);
        @(negedge clk_sys_i);
        chk(state_o, IBL_WAIT);
        chk(mask_clr_o, 1'h1);
        chk({cpu_clk_en_o, bus_clk_en_o, wdog_run_o}, 3'h3);
        cpu_mask_i <= 1'h0;
        irq_req_i  <= 20'h00002;
        wait_st(IBL_ENTRY, 6);
        chk(vector_o, 5'h02);
        irq_req_i <= 20'h00000;
        wait_st(IBL_RUN, 8);
    endtask
    // Short then long recovery; run_i stays low, so the core runs no instructions throughout
    task automatic t_stop;
        for (int i = 0; i < 2; i++) begin
            wr(`IBL_OFF_OPTIONS, i ? 8'h00 : 8'h01);
            op(3'h1);
            @(negedge clk_sys_i);
            chk({bus_clk_en_o, ref_clk_en_o, wdog_run_o}, 3'h0);
            cyc(3);
            irq_req_i <= 20'h00010;
            wait_st(IBL_RECOV, 8);
            wait_st(IBL_ENTRY, 4200);
            chk(n inside {[(i ? 4094 : 30):(i ? 4098 : 34)]}, 1'h1);
            irq_req_i <= 20'h00000;
            wait_st(IBL_RUN, 8);
        end
        wr(`IBL_OFF_OPTIONS, 8'h02);
        @(negedge clk_sys_i);
        chk(wdog_run_o, 1'h0);
    endtask
    task automatic t_brk;
        logic [7:0] d;
        emul_mode_i <= 1'h1;
        hold_i      <= 1'h1;
        op(3'h2);
        brk_req_i <= 1'h1;
        wait_st(IBL_ENTRY, 8);
        chk(vector_o, `IBL_VEC_SWI);
        rd(`IBL_OFF_BRK_STAT, d);
        chk(in_break_o, 1'h1);
        chk(d[`IBL_BRK_WAIT_BIT], 1'h1);
        flag_clr_req_i <= 1'h1;
        @(negedge clk_sys_i);
        chk(flag_clr_ok_o, 1'h0);
        wr(`IBL_OFF_BRK_CTRL, 8'h01);
        @(negedge clk_sys_i);
        chk(flag_clr_ok_o, 1'h1);
        brk_req_i <= 1'h0;
        hold_i    <= 1'h0;
        rst_unit;
        rd(`IBL_OFF_BRK_STAT, d);
        chk(d, 8'h00);
        chk(in_break_o, 1'h0);
        chk(flag_clr_ok_o, 1'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_unit;
        t_regs;
        t_prio;
        t_swi_wait;
        t_stop;
        t_brk;
        complete_run;
    end
    // Hang guard, well beyond the longest recovery
    initial begin
        #300us;
        mismatches++;
        complete_run;
    end
endmodule
